// >>> src/timer_two.sv
// Third 16-bit timer/counter with its control, mode, reload and count registers
// reached over the special-function-register port of the CPU core.
// Assumes the clock is the oscillator clock, the register port is synchronous,
// and the timer 1 overflow and interrupt enable come from logic on this clock.
`timescale 1ns/1ps
module timer_two (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Special-function-register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_write,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_read,
    output logic      [7:0] sfr_rdata,
    // External pins
    input  wire logic       count_pin,
    input  wire logic       trigger_pin,
    // Serial port clocking
    input  wire logic       timer_one_overflow,
    output logic            receive_clock_pulse,
    output logic            transmit_clock_pulse,
    // Interrupt request
    input  wire logic       interrupt_enable,
    output logic            interrupt_request
);

    typedef struct packed {
        logic [3:0]  machine_div;
        logic [0:0]  state_div;
        logic [7:0]  timer_two_control;
        logic [1:0]  timer_two_mode;
        logic [15:0] reload_value;
        logic [15:0] count;
        logic [7:0]  rdata;
        logic        rx_pulse;
        logic        tx_pulse;
        logic        irq;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    logic count_fall;
    logic trigger_level;
    logic trigger_fall;
    logic machine_enable;
    logic state_enable;

    // Register readback, used for the read port and for clarity of the map
    function automatic logic [7:0] read_mux(input logic [7:0] addr, input timer_state_t st);
        logic [7:0] value;
        value = timer_two_pkg::UNMAPPED_READ;
        unique case (addr)
            timer_two_pkg::ADDR_CONTROL:     value = st.timer_two_control;
            timer_two_pkg::ADDR_MODE:        value = {6'h00, st.timer_two_mode};
            timer_two_pkg::ADDR_RELOAD_LOW:  value = st.reload_value[7:0];
            timer_two_pkg::ADDR_RELOAD_HIGH: value = st.reload_value[15:8];
            timer_two_pkg::ADDR_COUNT_LOW:   value = st.count[7:0];
            timer_two_pkg::ADDR_COUNT_HIGH:  value = st.count[15:8];
            default:                         value = timer_two_pkg::UNMAPPED_READ;
        endcase
        return value;
    endfunction

    // Write strobe for one address
    function automatic logic hit(input logic [7:0] addr, input logic wr, input logic [7:0] target);
        return wr && (addr == target);
    endfunction

    // Operating mode; serial select overrides capture, and up/down needs auto-reload
    typedef enum logic [3:0] {
        MODE_RELOAD  = 4'b0001,
        MODE_CAPTURE = 4'b0010,
        MODE_BAUD    = 4'b0100,
        MODE_UP_DOWN = 4'b1000
    } count_mode_t;

    // Mode decode from the control and mode registers
    function automatic count_mode_t decode_mode(input logic [7:0] ctrl, input logic [1:0] mode);
        count_mode_t result;
        if (ctrl[timer_two_pkg::BIT_RECEIVE_CLOCK] | ctrl[timer_two_pkg::BIT_TRANSMIT_CLOCK]) begin
            result = MODE_BAUD;
        end else if (ctrl[timer_two_pkg::BIT_CAPTURE_SELECT]) begin
            result = MODE_CAPTURE;
        end else if (mode[timer_two_pkg::BIT_DOWN_COUNT_ENABLE]) begin
            result = MODE_UP_DOWN;
        end else begin
            result = MODE_RELOAD;
        end
        return result;
    endfunction

    // Flag next value: a hardware toggle or set beats a software write in the same cycle
    function automatic logic flag_next(input logic written, input logic current, input logic set,
                                       input logic toggle);
        logic result;
        result = written;
        if (toggle) begin
            result = ~current;
        end else if (set) begin
            result = 1'b1;
        end
        return result;
    endfunction

    // Rate enables from the oscillator divider
    assign machine_enable = (s.machine_div == timer_two_pkg::MACHINE_LAST);
    assign state_enable   = (s.state_div == timer_two_pkg::STATE_LAST);

    // Count pin and trigger pin, each sampled once per machine cycle
    pin_sampler count_sampler (
        .clock         (clock),
        .rst_n         (rst_n),
        .pin           (count_pin),
        .sample_enable (machine_enable),
        .level         (),
        .fall          (count_fall)
    );

    pin_sampler trigger_sampler (
        .clock         (clock),
        .rst_n         (rst_n),
        .pin           (trigger_pin),
        .sample_enable (machine_enable),
        .level         (trigger_level),
        .fall          (trigger_fall)
    );

    // Next-state logic for the whole timer
    always_comb begin
        logic       rclk;
        logic       transmit_clock_select;
        logic       baud;
        logic       run;
        logic       counter_mode;
        logic       capture_mode;
        logic       trig_en;
        logic       up_down;
        logic       tick;
        logic       overflow;
        logic       trigger_event;
        logic       set_overflow;
        logic       set_external;
        logic       toggle_external;
        logic [7:0] ctrl;
        count_mode_t mode;

        mode            = decode_mode(s.timer_two_control, s.timer_two_mode);
        rclk            = s.timer_two_control[timer_two_pkg::BIT_RECEIVE_CLOCK];
        transmit_clock_select            = s.timer_two_control[timer_two_pkg::BIT_TRANSMIT_CLOCK];
        baud            = (mode == MODE_BAUD);
        run             = s.timer_two_control[timer_two_pkg::BIT_RUN_CONTROL];
        counter_mode    = s.timer_two_control[timer_two_pkg::BIT_COUNTER_SELECT];
        capture_mode    = (mode == MODE_CAPTURE);
        trig_en         = s.timer_two_control[timer_two_pkg::BIT_TRIGGER_ENABLE];
        up_down         = (mode == MODE_UP_DOWN);
        tick            = 1'b0;
        overflow        = 1'b0;
        trigger_event   = 1'b0;
        set_overflow    = 1'b0;
        set_external    = 1'b0;
        toggle_external = 1'b0;
        ctrl            = s.timer_two_control;
        next_s          = s;

        // Oscillator dividers
        // Reset fixes the phase, so the first machine strobe comes 12 clocks after release
        next_s.machine_div = machine_enable ? 4'h0 : s.machine_div + 4'h1;
        next_s.state_div   = state_enable ? 1'b0 : s.state_div + 1'b1;

        // Pick the count source: pin edges, state times or machine cycles
        if (counter_mode) begin
            tick = count_fall;
        end else if (baud) begin
            tick = state_enable;
        end else begin
            tick = machine_enable;
        end
        tick = tick & run;

        // Counting, with overflow reload or wrap
        if (tick) begin
            if (up_down && !trigger_level) begin
                // Down count ends when the count meets the reload value
                if (s.count == s.reload_value) begin
                    next_s.count    = timer_two_pkg::COUNT_MAX;
                    overflow        = 1'b1;
                end else begin
                    next_s.count    = s.count - 16'h0001;
                end
            end else if (s.count == timer_two_pkg::COUNT_MAX) begin
                overflow     = 1'b1;
                next_s.count = capture_mode ? 16'h0000 : s.reload_value;
            end else begin
                next_s.count = s.count + 16'h0001;
            end
        end
        set_overflow    = overflow & ~baud;
        toggle_external = overflow & up_down;

        // Trigger falls; in up/down mode the pin is the direction, not a trigger
        trigger_event = trigger_fall & trig_en & ~up_down;
        if (trigger_event) begin
            set_external = 1'b1;
            if (capture_mode) begin
                next_s.reload_value = s.count;
            end else if (!baud) begin
                next_s.count = s.reload_value;
            end
        end

        // Software writes; the count and reload take the written byte over hardware
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_CONTROL)) begin
            ctrl = sfr_wdata;
        end
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_MODE)) begin
            next_s.timer_two_mode = sfr_wdata[1:0];
        end
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_RELOAD_LOW)) begin
            next_s.reload_value[7:0] = sfr_wdata;
        end
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_RELOAD_HIGH)) begin
            next_s.reload_value[15:8] = sfr_wdata;
        end
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_COUNT_LOW)) begin
            next_s.count[7:0] = sfr_wdata;
        end
        if (hit(sfr_addr, sfr_write, timer_two_pkg::ADDR_COUNT_HIGH)) begin
            next_s.count[15:8] = sfr_wdata;
        end

        // Hardware sets win over a software clear in the same cycle
        ctrl[timer_two_pkg::BIT_OVERFLOW_FLAG] = flag_next(ctrl[timer_two_pkg::BIT_OVERFLOW_FLAG],
            s.timer_two_control[timer_two_pkg::BIT_OVERFLOW_FLAG], set_overflow, 1'b0);
        ctrl[timer_two_pkg::BIT_EXTERNAL_FLAG] = flag_next(ctrl[timer_two_pkg::BIT_EXTERNAL_FLAG],
            s.timer_two_control[timer_two_pkg::BIT_EXTERNAL_FLAG], set_external, toggle_external);
        next_s.timer_two_control = ctrl;

        // Serial clock sources: this timer's overflow or timer 1's
        next_s.rx_pulse = rclk ? overflow : timer_one_overflow;
        next_s.tx_pulse = transmit_clock_select ? overflow : timer_one_overflow;

        // Interrupt from the flags as they will stand after this edge
        next_s.irq = interrupt_enable
                   & (ctrl[timer_two_pkg::BIT_OVERFLOW_FLAG]
                   | (ctrl[timer_two_pkg::BIT_EXTERNAL_FLAG] & ~up_down));

        // Count bytes are read one at a time, so a running count can tear between them
        // Registered read data; unmapped addresses answer zero
        if (sfr_read) begin
            next_s.rdata = read_mux(sfr_addr, s);
        end
    end

    // Single state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{machine_div:       4'h0,
                   state_div:         1'b0,
                   timer_two_control: timer_two_pkg::RESET_CONTROL,
                   timer_two_mode:    timer_two_pkg::RESET_MODE,
                   reload_value:      timer_two_pkg::RESET_RELOAD,
                   count:             timer_two_pkg::RESET_COUNT,
                   rdata:             8'h00,
                   rx_pulse:          1'b0,
                   tx_pulse:          1'b0,
                   irq:               1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata            = s.rdata;
    assign receive_clock_pulse  = s.rx_pulse;
    assign transmit_clock_pulse = s.tx_pulse;
    assign interrupt_request    = s.irq;

endmodule

// >>> src/timer_two_pkg.sv
// Constants shared by the third timer/counter: register addresses, field positions,
// reset values and the clock divisions that set its count rates.
// Assumes the clock input is the oscillator clock itself.
package timer_two_pkg;

    // Register addresses in the special-function space
    localparam logic [7:0] ADDR_CONTROL     = 8'hC8;
    localparam logic [7:0] ADDR_MODE        = 8'hC9;
    localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hCD;

    // Control register fields
    localparam int BIT_OVERFLOW_FLAG  = 7;
    localparam int BIT_EXTERNAL_FLAG  = 6;
    localparam int BIT_RECEIVE_CLOCK  = 5;
    localparam int BIT_TRANSMIT_CLOCK = 4;
    localparam int BIT_TRIGGER_ENABLE = 3;
    localparam int BIT_RUN_CONTROL    = 2;
    localparam int BIT_COUNTER_SELECT = 1;
    localparam int BIT_CAPTURE_SELECT = 0;

    // Mode register fields; bits 7..2 are not implemented and read as zero
    localparam int BIT_OUTPUT_ENABLE     = 1;
    localparam int BIT_DOWN_COUNT_ENABLE = 0;

    // Reset values
    localparam logic [7:0]  RESET_CONTROL = 8'h00;
    localparam logic [1:0]  RESET_MODE    = 2'h0;
    localparam logic [15:0] RESET_RELOAD  = 16'h0000;
    localparam logic [15:0] RESET_COUNT   = 16'h0000;
    localparam logic [7:0]  UNMAPPED_READ = 8'h00;

    // Count limits
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Rates: a machine cycle is 12 oscillator periods, a state time 2
    localparam int OSC_PER_MACHINE = 12;
    localparam int OSC_PER_STATE   = 2;
    localparam logic [3:0] MACHINE_LAST = 4'(OSC_PER_MACHINE - 1);
    localparam logic [0:0] STATE_LAST   = 1'(OSC_PER_STATE - 1);

endpackage

// >>> src/pin_sampler.sv
// Two-flop synchroniser for one external pin, then a once-per-machine-cycle
// sample that reports the sampled level and a high-then-low transition.
// Assumes sample_enable is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module pin_sampler (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Pin and sample strobe
    input  wire logic pin,
    input  wire logic sample_enable,
    // Results
    output logic      level,
    output logic      fall
);

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic sample;
        logic fall;
    } sampler_state_t;

    sampler_state_t s;
    sampler_state_t next_s;

    // Only sync_b reads sync_a; everything else looks at sync_b or later
    always_comb begin
        next_s        = s;
        next_s.sync_a = pin;
        next_s.sync_b = s.sync_a;
        next_s.fall   = 1'b0;
        if (sample_enable) begin
            next_s.sample = s.sync_b;
            next_s.fall   = s.sample & ~s.sync_b;
        end
    end

    // Pins idle high, so the samples reset high to avoid a false fall
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{sync_a: 1'b1, sync_b: 1'b1, sample: 1'b1, fall: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.sample;
    assign fall  = s.fall;

endmodule

// >>> testbench/timer_two_chk.sv
// Checker for the third timer: serial clock routing, register reads, interrupt gating.
// Sees only the top ports; keeps a shadow of the software-owned control bits 5..0.
`timescale 1ns/1ps
module timer_two_chk (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_write,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_read,
    input wire logic [7:0] sfr_rdata,
    // Pins and serial clocking
    input wire logic       count_pin,
    input wire logic       trigger_pin,
    input wire logic       timer_one_overflow,
    input wire logic       receive_clock_pulse,
    input wire logic       transmit_clock_pulse,
    // Interrupt
    input wire logic       interrupt_enable,
    input wire logic       interrupt_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Hardware never touches bits 5..0, so the last write predicts them
    logic [5:0] soft_bits;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            soft_bits <= 6'h00;
        else if (sfr_write && sfr_addr == timer_two_pkg::ADDR_CONTROL)
            soft_bits <= sfr_wdata[5:0];
    end
    // Stopped with receive select: three cycles let a late overflow drain
    sequence s_rx_idle;
        (soft_bits[5] && !soft_bits[2])[*3];
    endsequence
    sequence s_ctrl_read;
        sfr_read && sfr_addr == timer_two_pkg::ADDR_CONTROL;
    endsequence
    AST_RX_T1: assert property (!soft_bits[5] |=> receive_clock_pulse == $past(timer_one_overflow))
        else $error("receive clock not from timer one");
    AST_TX_T1: assert property (!soft_bits[4] |=> transmit_clock_pulse == $past(timer_one_overflow))
        else $error("transmit clock not from timer one");
    AST_STOP_QUIET: assert property (s_rx_idle |=> !receive_clock_pulse)
        else $error("receive clock pulse while timer stopped");
    AST_UNMAPPED: assert property (sfr_read && (sfr_addr < 8'hC8 || sfr_addr > 8'hCD) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_MODE_RESERVED: assert property (sfr_read && sfr_addr == 8'hC9 |=> sfr_rdata[7:2] == 6'h00)
        else $error("mode reserved bits not zero");
    AST_CTRL_SOFT: assert property (s_ctrl_read |=> sfr_rdata[5:0] == $past(soft_bits))
        else $error("control bits differ from last write");
    AST_IRQ_OFF: assert property (!interrupt_enable |=> !interrupt_request)
        else $error("interrupt request while disabled");
    AST_IRQ_CAUSE: assert property ($rose(interrupt_request) |-> $past(interrupt_enable, 1))
        else $error("interrupt request rose without enable");
endmodule
bind timer_two timer_two_chk i_timer_two_chk (
    .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
    .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .timer_one_overflow(timer_one_overflow), .receive_clock_pulse(receive_clock_pulse),
    .transmit_clock_pulse(transmit_clock_pulse), .interrupt_enable(interrupt_enable),
    .interrupt_request(interrupt_request)
);

// >>> testbench/pin_partner.sv
// Far side of the third timer: count and trigger pins, and timer 1 overflow pulses.
// Assumes the same clock as the timer; pins change just after a rising edge.
`timescale 1ns/1ps
module pin_partner (
    // Clock
    input  wire logic clock,
    // Pins and timer 1
    output logic      count_pin = 1'b1,
    output logic      trigger_pin = 1'b1,
    output logic      timer_one_overflow = 1'b0
);
    int t1_div = 0;
    // Timer 1 overflows every 7 clocks, off any multiple of the machine cycle
    always @(posedge clock) begin
        t1_div <= (t1_div == 6) ? 0 : t1_div + 1;
        timer_one_overflow <= (t1_div == 6);
    end
    // One falling edge; each level held two machine cycles so a sample sees it
    task automatic fall(input logic on_trigger);
        @(posedge clock);
        if (on_trigger)
            trigger_pin <= 1'b0;
        else
            count_pin <= 1'b0;
        repeat (24) @(posedge clock);
        trigger_pin <= 1'b1;
        count_pin <= 1'b1;
        repeat (24) @(posedge clock);
    endtask
    // Hold the trigger pin at one level, as the up/down direction input
    task automatic hold_trigger(input logic level);
        @(posedge clock);
        trigger_pin <= level;
    endtask
endmodule

// >>> testbench/timer_two_tb.sv
// Self-checking bench for the third timer: reset values, count rate, overflow,
// baud generation, capture, reload and event counting. Reads are scored from a queue.
`timescale 1ns/1ps
module timer_two_tb;
    typedef struct { logic [7:0] addr; logic [7:0] exp; } note_t;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_write = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_read = 1'b0;
    logic        interrupt_enable = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        count_pin;
    logic        trigger_pin;
    logic        timer_one_overflow;
    logic        receive_clock_pulse;
    logic        transmit_clock_pulse;
    logic        interrupt_request;
    logic        rd_seen = 1'b0;
    note_t       notes[$];
    note_t       note;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n_ticks;
    int          rx_count = 0;
    int          tx_count = 0;
    logic [31:0] seed = 32'h511FC949;

    timer_two i_timer_two (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
        .sfr_wdata(sfr_wdata), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .count_pin(count_pin),
        .trigger_pin(trigger_pin), .timer_one_overflow(timer_one_overflow),
        .receive_clock_pulse(receive_clock_pulse), .transmit_clock_pulse(transmit_clock_pulse),
        .interrupt_enable(interrupt_enable), .interrupt_request(interrupt_request));
    pin_partner i_pin_partner (.clock(clock), .count_pin(count_pin), .trigger_pin(trigger_pin),
        .timer_one_overflow(timer_one_overflow));

    initial begin
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One write, held until the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clock);
        sfr_write <= 1'b0;
    endtask

    // One read; the expected byte waits in the queue for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        sfr_addr <= a;
        sfr_read <= 1'b1;
        notes.push_back('{a, e});
        @(posedge clock);
        sfr_read <= 1'b0;
    endtask

    // Score read data the cycle after the read is taken; also cut a hang short
    always @(posedge clock) begin
        if (rd_seen && notes.size() > 0) begin
            note = notes.pop_front();
            check($sformatf("rdata at %h", note.addr), {8'h00, note.exp}, {8'h00, sfr_rdata});
        end
        rd_seen <= sfr_read;
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 8'hC7; a <= 8'hCF; a++) rd(8'(a), 8'h00);
        seed = lfsr_next(seed);
        wr(8'hCA, seed[7:0]);
        wr(8'hCB, seed[15:8]);
        wr(8'hCF, 8'h00);
        rd(8'hCA, seed[7:0]);
        rd(8'hCB, seed[15:8]);
        // Timer rate: exactly 12 clocks per count between the run and stop writes
        n_ticks = 3 + seed[18:16];
        wr(8'hC8, 8'h04);
        repeat (12 * n_ticks - 2) @(posedge clock);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'(n_ticks));
        repeat (30) @(posedge clock);
        rd(8'hCC, 8'(n_ticks));
        // Overflow in reload mode sets the flag and reloads
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        interrupt_enable <= 1'b1;
        wr(8'hC8, 8'h04);
        repeat (40) @(posedge clock);
        rd(8'hC8, 8'h84);
        rd(8'hCD, 8'h12);
        @(negedge clock);
        check("interrupt_request", 16'h0001, 16'(interrupt_request));
        wr(8'hC8, 8'h04);
        rd(8'hC8, 8'h04);
        @(negedge clock);
        check("interrupt_request", 16'h0000, 16'(interrupt_request));
        // Baud mode: 16 counts of two clocks each between overflows, flag untouched
        wr(8'hCA, 8'hF0);
        wr(8'hCB, 8'hFF);
        wr(8'hCC, 8'hF0);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h34);
        repeat (40) @(posedge clock);
        for (int i = 0; i < 320; i++) begin
            @(negedge clock);
            rx_count += (receive_clock_pulse === 1'b1);
            tx_count += (transmit_clock_pulse === 1'b1);
        end
        check("receive pulses", 16'd10, 16'(rx_count));
        check("transmit pulses", 16'd10, 16'(tx_count));
        rd(8'hC8, 8'h34);
        // Serial selects kept with the timer stopped: no receive pulses once a late overflow has drained
        wr(8'hC8, 8'h30);
        repeat (6) @(posedge clock);
        wr(8'hC8, 8'h00);
        // Capture on trigger fall, then the trigger ignored when not enabled
        wr(8'hCC, 8'hCD);
        wr(8'hCD, 8'hAB);
        wr(8'hC8, 8'h09);
        i_pin_partner.fall(1'b1);
        rd(8'hCA, 8'hCD);
        rd(8'hCB, 8'hAB);
        rd(8'hC8, 8'h49);
        @(negedge clock);
        check("interrupt_request", 16'h0001, 16'(interrupt_request));
        wr(8'hC8, 8'h01);
        wr(8'hCC, 8'h11);
        i_pin_partner.fall(1'b1);
        rd(8'hCA, 8'hCD);
        rd(8'hC8, 8'h01);
        // Reload on trigger fall
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h08);
        i_pin_partner.fall(1'b1);
        rd(8'hCC, 8'hCD);
        rd(8'hC8, 8'h48);
        // Up/down mode, trigger low: count down to the reload value, then load all ones
        wr(8'hCA, 8'h05);
        wr(8'hCB, 8'h00);
        wr(8'hCC, 8'h06);
        wr(8'hCD, 8'h00);
        wr(8'hC9, 8'h01);
        i_pin_partner.hold_trigger(1'b0);
        repeat (30) @(posedge clock);
        wr(8'hC8, 8'h04);
        repeat (40) @(posedge clock);
        rd(8'hC8, 8'hC4);
        rd(8'hCD, 8'hFF);
        wr(8'hC8, 8'h40);
        @(negedge clock);
        check("interrupt_request", 16'h0000, 16'(interrupt_request));
        i_pin_partner.hold_trigger(1'b1);
        wr(8'hC9, 8'h00);
        interrupt_enable <= 1'b0;
        // Event counting on count pin falls
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h06);
        repeat (3) i_pin_partner.fall(1'b0);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h03);
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule
